/* File: design/ncx_pkg.sv */
package ncx_pkg;

	// Register byte addresses
	localparam logic [7:0] ADDR_IOCFG1   = 8'h00;
	localparam logic [7:0] ADDR_IOCFG2   = 8'h04;
	localparam logic [7:0] ADDR_OPCTL    = 8'h08;
	localparam logic [7:0] ADDR_MODEDEF  = 8'h0C;
	localparam logic [7:0] ADDR_BITRATE  = 8'h10;
	localparam logic [7:0] ADDR_AUXDEF   = 8'h14;
	localparam logic [7:0] ADDR_RXCFG    = 8'h18;
	localparam logic [7:0] ADDR_TXCFG    = 8'h1C;
	localparam logic [7:0] ADDR_TIMERCTL = 8'h20;
	localparam logic [7:0] ADDR_FDTHR    = 8'h24;
	localparam logic [7:0] ADDR_IRQ      = 8'h28;
	localparam logic [7:0] ADDR_COLL     = 8'h2C;
	localparam logic [7:0] ADDR_FIFOSTAT = 8'h30;
	localparam logic [7:0] ADDR_FIFODATA = 8'h34;
	localparam logic [7:0] ADDR_CMD      = 8'h38;
	localparam logic [7:0] ADDR_CALRES   = 8'h3C;
	localparam logic [7:0] ADDR_NBTX     = 8'h40;
	localparam logic [7:0] ADDR_STATUS   = 8'h44;
	localparam logic [7:0] ADDR_BRDISP   = 8'h48;

	// Field positions
	localparam int OPCTL_EN      = 7;
	localparam int OPCTL_RX_EN   = 6;
	localparam int OPCTL_TX_EN   = 3;
	localparam int MODE_AUTO_RCA = 0;
	localparam int MODE_RATE_DET = 3;
	localparam int AUX_SLOT_LO   = 0;
	localparam int AUX_SLOT_HI   = 1;
	localparam int AUX_TX_AM     = 5;
	localparam int TMR_NRT_KEEP  = 0;
	localparam int TMR_GPT       = 4;
	localparam int TMR_WUT       = 5;
	localparam int TMR_MRT       = 6;
	localparam int TMR_NRT       = 7;
	localparam int IRQ_FO_DONE   = 0;
	localparam int IRQ_COLL      = 1;

	// Reset values
	localparam logic [7:0]  RST_REG8  = 8'h00;
	localparam logic [7:0]  RST_FDTHR = 8'h80;
	localparam logic [15:0] RST_NBTX  = 16'h0000;

	// Command codes
	localparam logic [7:0] CMD_SET_DEFAULT = 8'hC1;
	localparam logic [7:0] CMD_CLEAR       = 8'hC2;
	localparam logic [7:0] CMD_TX_CRC      = 8'hC4;
	localparam logic [7:0] CMD_TX_NOCRC    = 8'hC5;
	localparam logic [7:0] CMD_TX_REQA     = 8'hC6;
	localparam logic [7:0] CMD_TX_WUPA     = 8'hC7;
	localparam logic [7:0] CMD_FO_INITIAL  = 8'hC8;
	localparam logic [7:0] CMD_FO_RESP     = 8'hC9;
	localparam logic [7:0] CMD_FO_RESP_N0  = 8'hCA;
	localparam logic [7:0] CMD_GO_NORMAL   = 8'hCB;
	localparam logic [7:0] CMD_ANALOG_PRE  = 8'hCC;

	// Timing in carrier periods and in time units
	localparam longint FC_HZ             = 64'd13560000;
	localparam longint CLK_HZ            = 64'd250000000;
	localparam longint INITIAL_DELAY_FC  = 64'd4096;
	localparam longint RF_WAITING_FC     = 64'd512;
	localparam longint ACTIVE_DELAY_FC   = 64'd768;
	localparam longint ACTIVE_GUARD_FC   = 64'd1024;
	localparam longint INITIAL_GUARD_MS  = 64'd5;
	localparam int FIFO_DEPTH            = 96;

	// Least times round up; the initial guard must exceed its figure, hence one extra cycle
	localparam longint INITIAL_DELAY_CYC = (INITIAL_DELAY_FC * CLK_HZ + FC_HZ - 1) / FC_HZ;
	localparam longint RF_WAITING_CYC    = (RF_WAITING_FC * CLK_HZ + FC_HZ - 1) / FC_HZ;
	localparam longint ACTIVE_DELAY_CYC  = (ACTIVE_DELAY_FC * CLK_HZ + FC_HZ - 1) / FC_HZ;
	localparam longint ACTIVE_GUARD_CYC  = (ACTIVE_GUARD_FC * CLK_HZ + FC_HZ - 1) / FC_HZ;
	localparam longint INITIAL_GUARD_CYC = INITIAL_GUARD_MS * CLK_HZ / 64'd1000 + 64'd1;

	typedef enum logic [1:0] {
		TXK_CRC   = 2'b00,
		TXK_NOCRC = 2'b01,
		TXK_REQA  = 2'b10,
		TXK_WUPA  = 2'b11
	} ncx_txkind_t;

	typedef struct packed {
		logic        tx_start;
		ncx_txkind_t tx_kind;
		logic        fifo_flush;
		logic        activity_abort;
		logic        tx_en;
		logic        rx_en;
	} ncx_ctl_t;

	typedef struct packed {
		logic [7:0] rx_cfg;
		logic [7:0] tx_cfg;
		logic [7:0] bitrate;
		logic       tx_am_select;
	} ncx_cfg_t;

endpackage

/* File: design/ncx_direct_cmd.sv */
module ncx_direct_cmd #(
	parameter int unsigned P_INIT_DELAY_CYC  = 32'(ncx_pkg::INITIAL_DELAY_CYC),
	parameter int unsigned P_RF_WAIT_CYC     = 32'(ncx_pkg::RF_WAITING_CYC),
	parameter int unsigned P_INIT_GUARD_CYC  = 32'(ncx_pkg::INITIAL_GUARD_CYC),
	parameter int unsigned P_ACT_DELAY_CYC   = 32'(ncx_pkg::ACTIVE_DELAY_CYC),
	parameter int unsigned P_ACT_GUARD_CYC   = 32'(ncx_pkg::ACTIVE_GUARD_CYC)
) (
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	input  wire logic             psel_i,
	input  wire logic             penable_i,
	input  wire logic             pwrite_i,
	input  wire logic [7:0]       paddr_i,
	input  wire logic [31:0]      pwdata_i,
	output logic      [31:0]      prdata_o,
	output logic                  pready_o,
	output logic                  pslverr_o,
	input  wire logic             xtal_freq_ok_i,
	input  wire logic             xtal_ampl_ok_i,
	input  wire logic [7:0]       rf_level_i,
	input  wire logic [7:0]       rate_display_i,
	input  wire logic             tx_done_i,
	output ncx_pkg::ncx_ctl_t     ctl_o,
	output ncx_pkg::ncx_cfg_t     cfg_o,
	output logic      [1:0]       irq_flags_o
);
	import ncx_pkg::*;

	if (P_INIT_DELAY_CYC < 1 || P_RF_WAIT_CYC < 1 || P_INIT_GUARD_CYC < 1 ||
	    P_ACT_DELAY_CYC < 1 || P_ACT_GUARD_CYC < 1) begin : g_bad_timing
		$error("ncx_direct_cmd: every timing count must be at least one cycle");
	end

	typedef enum logic [1:0] {
		FO_IDLE  = 2'b00,
		FO_DELAY = 2'b01,
		FO_GUARD = 2'b11
	} ncx_fo_state_t;

	// Analog preset tables
	function automatic logic [7:0] ncx_rx_preset(input logic [7:0] mode, input logic [7:0] rate);
		logic [7:0] v;
		v = 8'h00;
		v[7] = mode[MODE_RATE_DET];
		v[6] = (rate[1:0] == 2'h3);
		v[5:3] = rate[2:0];
		v[2:0] = mode[6:4];
		return v;
	endfunction

	function automatic logic [7:0] ncx_tx_preset(input logic [7:0] mode, input logic [7:0] rate);
		logic [7:0] v;
		v = 8'h00;
		v[7:4] = mode[7:4];
		v[3:0] = rate[3:0];
		return v;
	endfunction

	function automatic logic ncx_rate_is_am(input logic [7:0] rate);
		return (rate[3:0] != 4'h0);
	endfunction

	// Pin synchronisers
	logic [2:0] freq_sync_ff;
	logic [2:0] ampl_sync_ff;
	logic       freq_ok_ff;
	logic       ampl_ok_ff;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			freq_sync_ff <= 3'h0;
			ampl_sync_ff <= 3'h0;
			freq_ok_ff   <= 1'b0;
			ampl_ok_ff   <= 1'b0;
		end else begin
			freq_sync_ff <= {freq_sync_ff[1:0], xtal_freq_ok_i};
			ampl_sync_ff <= {ampl_sync_ff[1:0], xtal_ampl_ok_i};
			if (freq_sync_ff[1] == freq_sync_ff[2]) begin
				freq_ok_ff <= freq_sync_ff[2];
			end
			if (ampl_sync_ff[1] == ampl_sync_ff[2]) begin
				ampl_ok_ff <= ampl_sync_ff[2];
			end
		end
	end

	// APB decode
	logic       acc;
	logic       wr;
	logic       rd;
	logic       mapped;
	logic       pready_ff;
	logic       pslverr_ff;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;

	assign acc = psel_i & penable_i & ~pready_ff;
	assign wr  = acc & pwrite_i;
	assign rd  = acc & ~pwrite_i;

	// Register state
	logic [7:0]  iocfg1_ff;
	logic [7:0]  iocfg2_ff;
	logic [7:0]  opctl_ff;
	logic [7:0]  modedef_ff;
	logic [7:0]  bitrate_ff;
	logic [7:0]  auxdef_ff;
	logic [7:0]  rxcfg_ff;
	logic [7:0]  txcfg_ff;
	logic        nrt_keep_ff;
	logic [3:0]  tmr_run_ff;
	logic [7:0]  fdthr_ff;
	logic [1:0]  irq_ff;
	logic [7:0]  coll_ff;
	logic [6:0]  fifo_lvl_ff;
	logic        fifo_ovf_ff;
	logic [7:0]  calres_ff;
	logic [15:0] nbtx_ff;
	logic        tx_busy_ff;
	ncx_ctl_t    ctl_ff;

	// Command decode and acceptance
	logic       cmd_wr;
	logic [7:0] cmd;
	logic       en;
	logic       ok_set_default;
	logic       ok_clear;
	logic       ok_tx;
	logic       ok_fo;
	logic       ok_go_normal;
	logic       ok_preset;
	logic       is_tx_cmd;
	logic       is_fo_cmd;

	assign cmd_wr    = wr & (paddr_i == ADDR_CMD);
	assign cmd       = pwdata_i[7:0];
	assign en        = opctl_ff[OPCTL_EN];
	assign is_tx_cmd = (cmd == CMD_TX_CRC) | (cmd == CMD_TX_NOCRC) |
	                   (cmd == CMD_TX_REQA) | (cmd == CMD_TX_WUPA);
	assign is_fo_cmd = (cmd == CMD_FO_INITIAL) | (cmd == CMD_FO_RESP) | (cmd == CMD_FO_RESP_N0);

	assign ok_set_default = cmd_wr & (cmd == CMD_SET_DEFAULT);
	assign ok_clear       = cmd_wr & (cmd == CMD_CLEAR) & en & freq_ok_ff;
	assign ok_tx          = cmd_wr & is_tx_cmd & en & opctl_ff[OPCTL_TX_EN];
	assign ok_fo          = cmd_wr & is_fo_cmd & en & freq_ok_ff & ampl_ok_ff;
	assign ok_go_normal   = cmd_wr & (cmd == CMD_GO_NORMAL) & modedef_ff[MODE_RATE_DET];
	assign ok_preset      = cmd_wr & (cmd == CMD_ANALOG_PRE);
	// unaccepted codes fall through; they drive no update below

	// Field-on sequencer
	ncx_fo_state_t fo_state_ff;
	logic [31:0]   fo_cnt_ff;
	logic          fo_resp_ff;
	logic [15:0]   lfsr_ff;
	logic [1:0]    slot_n;
	logic [1:0]    slot_r;
	logic [31:0]   delay_cyc;
	logic          foreign_field;
	logic          fo_keep;
	logic          fo_abort;
	logic          fo_coll;
	logic          fo_done;

	// n from the slot bits, forced to zero for the n=0 variant
	assign slot_n = (cmd == CMD_FO_RESP_N0) ? 2'h0 :
	                {auxdef_ff[AUX_SLOT_HI], auxdef_ff[AUX_SLOT_LO]};
	assign slot_r = (lfsr_ff[1:0] <= slot_n) ? lfsr_ff[1:0] : slot_n;
	// initial or active delay, plus RF waiting slots in both cases
	assign delay_cyc = ((cmd == CMD_FO_INITIAL) ? P_INIT_DELAY_CYC : P_ACT_DELAY_CYC) +
	                   32'(slot_r) * P_RF_WAIT_CYC;
	assign foreign_field = (rf_level_i >= fdthr_ff);
	assign fo_keep  = fo_resp_ff & modedef_ff[MODE_AUTO_RCA];
	assign fo_abort = (ok_clear & ~fo_keep) | ok_set_default;
	// collision during the delay ends the attempt
	assign fo_coll  = (fo_state_ff == FO_DELAY) & foreign_field & ~fo_abort;
	assign fo_done  = (fo_state_ff == FO_GUARD) & (fo_cnt_ff == 32'h1) & ~fo_abort;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lfsr_ff <= 16'hACE1;
		end else begin
			lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fo_state_ff <= FO_IDLE;
			fo_cnt_ff   <= 32'h0;
			fo_resp_ff  <= 1'b0;
		end else if (fo_abort) begin
			fo_state_ff <= FO_IDLE;
			fo_cnt_ff   <= 32'h0;
		end else begin
			case (fo_state_ff)
				FO_IDLE: begin
					if (ok_fo) begin
						fo_state_ff <= FO_DELAY;
						fo_cnt_ff   <= delay_cyc;
						fo_resp_ff  <= (cmd != CMD_FO_INITIAL);
					end
				end
				FO_DELAY: begin
					if (foreign_field) begin
						fo_state_ff <= FO_IDLE;
					end else if (fo_cnt_ff == 32'h1) begin
						fo_state_ff <= FO_GUARD;
						fo_cnt_ff   <= fo_resp_ff ? P_ACT_GUARD_CYC : P_INIT_GUARD_CYC;
					end else begin
						fo_cnt_ff <= fo_cnt_ff - 32'h1;
					end
				end
				FO_GUARD: begin
					if (fo_cnt_ff == 32'h1) begin
						fo_state_ff <= FO_IDLE;
					end else begin
						fo_cnt_ff <= fo_cnt_ff - 32'h1;
					end
				end
				default: begin
					fo_state_ff <= FO_IDLE;
				end
			endcase
		end
	end

	// Operation control, IO configuration
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			iocfg1_ff <= RST_REG8;
			iocfg2_ff <= RST_REG8;
			opctl_ff  <= RST_REG8;
		end else begin
			if (wr & (paddr_i == ADDR_IOCFG1)) begin
				iocfg1_ff <= pwdata_i[7:0];
			end
			if (wr & (paddr_i == ADDR_IOCFG2)) begin
				iocfg2_ff <= pwdata_i[7:0];
			end
			if (wr & (paddr_i == ADDR_OPCTL)) begin
				opctl_ff <= pwdata_i[7:0];
			end
			// field switched on at the same edge that the guard time starts
			if (fo_state_ff == FO_DELAY && fo_cnt_ff == 32'h1 && !foreign_field && !fo_abort) begin
				opctl_ff[OPCTL_TX_EN] <= 1'b1;
			end
		end
	end

	// Configuration registers
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			modedef_ff <= RST_REG8;
			bitrate_ff <= RST_REG8;
			auxdef_ff  <= RST_REG8;
			rxcfg_ff   <= RST_REG8;
			txcfg_ff   <= RST_REG8;
			fdthr_ff   <= RST_FDTHR;
			nbtx_ff    <= RST_NBTX;
			calres_ff  <= RST_REG8;
		end else if (ok_set_default) begin
			modedef_ff <= RST_REG8;
			bitrate_ff <= RST_REG8;
			auxdef_ff  <= RST_REG8;
			rxcfg_ff   <= RST_REG8;
			txcfg_ff   <= RST_REG8;
			fdthr_ff   <= RST_FDTHR;
			nbtx_ff    <= RST_NBTX;
			calres_ff  <= RST_REG8;
		end else begin
			if (wr & (paddr_i == ADDR_MODEDEF)) begin
				modedef_ff <= pwdata_i[7:0];
			end else if (ok_go_normal) begin
				modedef_ff[MODE_RATE_DET] <= 1'b0;
			end
			if (wr & (paddr_i == ADDR_BITRATE)) begin
				bitrate_ff <= pwdata_i[7:0];
			end else if (ok_go_normal) begin
				bitrate_ff <= rate_display_i;
			end
			if (wr & (paddr_i == ADDR_AUXDEF)) begin
				auxdef_ff <= pwdata_i[7:0];
			end else if (ok_go_normal) begin
				auxdef_ff[AUX_TX_AM] <= ncx_rate_is_am(rate_display_i);
			end
			if (wr & (paddr_i == ADDR_RXCFG)) begin
				rxcfg_ff <= pwdata_i[7:0];
			end else if (ok_preset) begin
				rxcfg_ff <= ncx_rx_preset(modedef_ff, bitrate_ff);
			end
			if (wr & (paddr_i == ADDR_TXCFG)) begin
				txcfg_ff <= pwdata_i[7:0];
			end else if (ok_preset) begin
				txcfg_ff <= ncx_tx_preset(modedef_ff, bitrate_ff);
			end
			if (wr & (paddr_i == ADDR_FDTHR)) begin
				fdthr_ff <= pwdata_i[7:0];
			end
			if (wr & (paddr_i == ADDR_NBTX)) begin
				nbtx_ff <= pwdata_i[15:0];
			end
			if (wr & (paddr_i == ADDR_CALRES)) begin
				calres_ff <= pwdata_i[7:0];
			end
		end
	end

	// Timers
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			nrt_keep_ff <= 1'b0;
			tmr_run_ff  <= 4'h0;
		end else if (ok_set_default) begin
			nrt_keep_ff <= 1'b0;
			tmr_run_ff  <= 4'h0;
		end else if (ok_clear) begin
			// stop all but wake-up; no-response kept on request
			tmr_run_ff[TMR_GPT - 4] <= 1'b0;
			tmr_run_ff[TMR_MRT - 4] <= 1'b0;
			if (!nrt_keep_ff) begin
				tmr_run_ff[TMR_NRT - 4] <= 1'b0;
			end
		end else if (wr & (paddr_i == ADDR_TIMERCTL)) begin
			nrt_keep_ff <= pwdata_i[TMR_NRT_KEEP];
			tmr_run_ff  <= tmr_run_ff | pwdata_i[7:4];
		end
	end

	// Interrupt flags, collision, FIFO level: hardware set of the interrupt flags wins over clear; a clear wins over a FIFO data write
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_ff      <= 2'h0;
			coll_ff     <= RST_REG8;
			fifo_lvl_ff <= 7'h0;
			fifo_ovf_ff <= 1'b0;
		end else begin
			if (ok_set_default | ok_clear) begin
				irq_ff  <= 2'h0;
				coll_ff <= RST_REG8;
			end else if (wr & (paddr_i == ADDR_IRQ)) begin
				irq_ff <= irq_ff & ~pwdata_i[1:0];
			end else if (wr & (paddr_i == ADDR_COLL)) begin
				coll_ff <= pwdata_i[7:0];
			end
			if (fo_done) begin
				irq_ff[IRQ_FO_DONE] <= 1'b1;
			end
			if (fo_coll) begin
				irq_ff[IRQ_COLL] <= 1'b1;
			end
			// FIFO kept when enable is clear; clear empties it
			if ((ok_set_default & en) | ok_clear) begin
				fifo_lvl_ff <= 7'h0;
				fifo_ovf_ff <= 1'b0;
			end else if (ok_tx & (cmd == CMD_TX_CRC || cmd == CMD_TX_NOCRC)) begin
				fifo_lvl_ff <= 7'h0;
			end else if (wr & (paddr_i == ADDR_FIFODATA)) begin
				if (fifo_lvl_ff == 7'(FIFO_DEPTH)) begin
					fifo_ovf_ff <= 1'b1;
				end else begin
					fifo_lvl_ff <= fifo_lvl_ff + 7'h1;
				end
			end
		end
	end

	// Transmit and activity control
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctl_ff     <= '0;
			tx_busy_ff <= 1'b0;
		end else begin
			ctl_ff.tx_start       <= 1'b0;
			ctl_ff.fifo_flush     <= (ok_set_default & en) | ok_clear;
			ctl_ff.activity_abort <= ok_clear | ok_set_default;
			ctl_ff.tx_en          <= opctl_ff[OPCTL_TX_EN];
			ctl_ff.rx_en          <= opctl_ff[OPCTL_RX_EN];
			if (ok_tx) begin
				// REQA and WUPA go without FIFO data
				ctl_ff.tx_start <= 1'b1;
				case (cmd)
					CMD_TX_CRC:   ctl_ff.tx_kind <= TXK_CRC;
					CMD_TX_NOCRC: ctl_ff.tx_kind <= TXK_NOCRC;
					CMD_TX_REQA:  ctl_ff.tx_kind <= TXK_REQA;
					default:      ctl_ff.tx_kind <= TXK_WUPA;
				endcase
			end
			if (ok_clear | ok_set_default | tx_done_i) begin
				tx_busy_ff <= 1'b0;
			end else if (ok_tx) begin
				tx_busy_ff <= 1'b1;
			end
		end
	end

	// APB slave: one wait state, then answer
	always_comb begin
		mapped     = 1'b1;
		nxt_prdata = 32'h0;
		case (paddr_i)
			ADDR_IOCFG1:   nxt_prdata[7:0] = iocfg1_ff;
			ADDR_IOCFG2:   nxt_prdata[7:0] = iocfg2_ff;
			ADDR_OPCTL:    nxt_prdata[7:0] = opctl_ff;
			ADDR_MODEDEF:  nxt_prdata[7:0] = modedef_ff;
			ADDR_BITRATE:  nxt_prdata[7:0] = bitrate_ff;
			ADDR_AUXDEF:   nxt_prdata[7:0] = auxdef_ff;
			ADDR_RXCFG:    nxt_prdata[7:0] = rxcfg_ff;
			ADDR_TXCFG:    nxt_prdata[7:0] = txcfg_ff;
			ADDR_TIMERCTL: nxt_prdata[7:0] = {tmr_run_ff, 3'h0, nrt_keep_ff};
			ADDR_FDTHR:    nxt_prdata[7:0] = fdthr_ff;
			ADDR_IRQ:      nxt_prdata[1:0] = irq_ff;
			ADDR_COLL:     nxt_prdata[7:0] = coll_ff;
			ADDR_FIFOSTAT: nxt_prdata[7:0] = {fifo_ovf_ff, fifo_lvl_ff};
			ADDR_FIFODATA: nxt_prdata      = 32'h0;
			ADDR_CMD:      nxt_prdata      = 32'h0;
			ADDR_CALRES:   nxt_prdata[7:0] = calres_ff;
			ADDR_NBTX:     nxt_prdata[15:0] = nbtx_ff;
			ADDR_STATUS:   nxt_prdata[5:0] = {tx_busy_ff, ampl_ok_ff, freq_ok_ff,
			                                  modedef_ff[MODE_RATE_DET],
			                                  fo_state_ff == FO_GUARD,
			                                  fo_state_ff != FO_IDLE};
			ADDR_BRDISP:   nxt_prdata[7:0] = rate_display_i;
			default:       mapped          = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0;
		end else begin
			pready_ff  <= acc;
			pslverr_ff <= acc & ~mapped;
			if (rd) begin
				prdata_ff <= nxt_prdata;
			end
		end
	end

	assign prdata_o    = prdata_ff;
	assign pready_o    = pready_ff;
	assign pslverr_o   = pslverr_ff;
	assign ctl_o       = ctl_ff;
	assign cfg_o       = '{rx_cfg: rxcfg_ff, tx_cfg: txcfg_ff, bitrate: bitrate_ff,
	                       tx_am_select: auxdef_ff[AUX_TX_AM]};
	assign irq_flags_o = irq_ff;

endmodule

/* File: tb/ncx_direct_cmd_checker.sv */
module ncx_direct_cmd_checker
	import ncx_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_b_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire ncx_ctl_t    ctl_o,
	input wire logic [1:0]  irq_flags_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	logic take;
	assign take = psel_i && penable_i && !pready_o;
	a_ready_answer: assert property (take |=> pready_o)
		else $error("access not answered");
	a_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("ready longer than one cycle");
	a_err_with_ready: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
	a_err_unmapped: assert property (take && paddr_i > 8'h48 |=> pslverr_o)
		else $error("unmapped access not refused");
	a_rdata_hold: assert property (!(take && !pwrite_i) |=> $stable(prdata_o))
		else $error("read data moved without a read");
	a_tx_needs_en: assert property (ctl_o.tx_start |-> ctl_o.tx_en)
		else $error("transmit without transmitter enable");
	a_done_after_en: assert property ($rose(irq_flags_o[0]) |-> ctl_o.tx_en)
		else $error("field-on done without field");
	a_coll_no_field: assert property ($rose(irq_flags_o[1]) |-> $stable(ctl_o.tx_en))
		else $error("collision switched the field");
	a_abort_flush: assert property (ctl_o.fifo_flush |-> ctl_o.activity_abort)
		else $error("FIFO flush without abort");
endmodule

bind ncx_direct_cmd ncx_direct_cmd_checker u_ncx_direct_cmd_checker (.clk_i(clk_i),
	.rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
	.paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.ctl_o(ctl_o), .irq_flags_o(irq_flags_o));

/* File: tb/ncx_apb_host.sv */
module ncx_apb_host (
	input wire logic        clk_i,
	input wire logic        pready_i,
	input wire logic        pslverr_i,
	input wire logic [31:0] prdata_i,
	output logic            psel_o,
	output logic            penable_o,
	output logic            pwrite_o,
	output logic [7:0]      paddr_o,
	output logic [31:0]     pwdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tmo = 1'b0;
	initial {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;

	// Holds the request until ready is seen; bounded so a hang is reported
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		int n;
		@(posedge clk_i);
		psel_o <= 1'b1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clk_i);
		penable_o <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_i !== 1'b1 && n < 20);
		tmo = (pready_i !== 1'b1);
		r = prdata_i;
		e = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
	endtask
endmodule

/* File: tb/nfc_reader_direct_command_exec_bench.sv */
module nfc_reader_direct_command_exec_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import ncx_pkg::*;
	localparam int P_ID = 12;
	localparam int P_RW = 8;
	localparam int P_IG = 16;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr, err;
	logic        f_ok = 1'b0;
	logic        a_ok = 1'b0;
	logic [7:0]  paddr;
	logic [7:0]  rf_lvl = 8'h00;
	logic [7:0]  rate = 8'h00;
	logic [31:0] pwdata, prdata, rd, v;
	logic [31:0] seed = 32'h61BA;
	logic [1:0]  irq;
	ncx_ctl_t    ctl;
	ncx_cfg_t    cfg;
	int          fails = 0;
	int          n_tests = 0;
	int          m_fifo, n;
	ncx_txkind_t kq[$];

	always #2 clk = ~clk;
	always @(posedge clk) if (ctl.tx_start === 1'b1) kq.push_back(ctl.tx_kind);

	ncx_direct_cmd #(.P_INIT_DELAY_CYC(P_ID), .P_RF_WAIT_CYC(P_RW), .P_INIT_GUARD_CYC(P_IG),
		.P_ACT_DELAY_CYC(10), .P_ACT_GUARD_CYC(12)) u_ncx_direct_cmd (.clk_i(clk),
		.rst_b_i(rst_b), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .xtal_freq_ok_i(f_ok), .xtal_ampl_ok_i(a_ok),
		.rf_level_i(rf_lvl), .rate_display_i(rate), .tx_done_i(1'b0), .ctl_o(ctl),
		.cfg_o(cfg), .irq_flags_o(irq));
	ncx_apb_host u_ncx_apb_host (.clk_i(clk), .pready_i(pready), .pslverr_i(pslverr),
		.prdata_i(prdata), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
		.paddr_o(paddr), .pwdata_o(pwdata));

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task report_and_stop();
		if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		u_ncx_apb_host.xfer(w, a, d, rd, err);
		if (u_ncx_apb_host.tmo) begin
			fails++;
			report_and_stop();
		end
	endtask
	task cmd(input logic [7:0] c);
		acc(1'b1, ADDR_CMD, {24'h0, c});
	endtask
	task wait_irq(input int b);
		n = 0;
		while (irq[b] !== 1'b1 && n < 300) begin
			@(posedge clk);
			n++;
		end
		if (n == 300) begin
			fails++;
			report_and_stop();
		end
	endtask

	initial begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		f_ok <= 1'b1;
		a_ok <= 1'b1;
		repeat (6) @(posedge clk);
		acc(0, ADDR_FDTHR, 0);
		chk("fdthr reset", rd, 32'h80);
		acc(0, 8'h80, 0);
		chk("unmapped error", {31'h0, err}, 1);
		m_fifo = 3;
		repeat (3) acc(1, ADDR_FIFODATA, rnd());
		cmd(CMD_CLEAR);
		acc(0, ADDR_FIFOSTAT, 0);
		chk("refused clear", rd, m_fifo);
		v = rnd() & 32'hFF;
		acc(1, ADDR_IOCFG1, v);
		acc(1, ADDR_OPCTL, 32'h40);
		acc(1, ADDR_CALRES, 32'h7);
		acc(1, ADDR_FDTHR, 32'h11);
		cmd(CMD_SET_DEFAULT);
		acc(0, ADDR_FIFOSTAT, 0);
		chk("fifo kept", rd, m_fifo);
		acc(0, ADDR_IOCFG1, 0);
		chk("iocfg kept", rd, v);
		acc(0, ADDR_OPCTL, 0);
		chk("opctl kept", rd, 32'h40);
		acc(0, ADDR_FDTHR, 0);
		chk("fdthr default", rd, 32'h80);
		acc(0, ADDR_CALRES, 0);
		chk("cal wiped", rd, 0);
		acc(1, ADDR_OPCTL, 32'h80);
		cmd(CMD_CLEAR);
		m_fifo = 0;
		acc(0, ADDR_FIFOSTAT, 0);
		chk("clear fifo", rd, m_fifo);
		acc(1, ADDR_TIMERCTL, 32'hF1);
		cmd(CMD_CLEAR);
		acc(0, ADDR_TIMERCTL, 0);
		chk("timers after clear", rd, 32'hA1);
		cmd(CMD_TX_REQA);
		repeat (3) @(posedge clk);
		chk("tx refused", 32'(kq.size()), 0);
		// clear, byte count, then data; valid-bit count zero
		acc(1, ADDR_OPCTL, 32'h88);
		cmd(CMD_CLEAR);
		acc(1, ADDR_NBTX, 32'h8);
		acc(1, ADDR_FIFODATA, rnd());
		for (int k = 0; k < 4; k++) cmd(CMD_TX_CRC + 8'(k));
		repeat (3) @(posedge clk);
		chk("tx count", 32'(kq.size()), 4);
		for (int k = 0; k < 4; k++) chk("tx kind", 32'(kq[k]), k);
		acc(1, ADDR_OPCTL, 32'h80);
		acc(1, ADDR_AUXDEF, rnd() & 32'h3);
		cmd(CMD_FO_INITIAL);
		wait_irq(0);
		chk("initial time", n >= P_ID + P_IG - 2 && n <= P_ID + 3 * P_RW + P_IG + 2, 1);
		acc(0, ADDR_OPCTL, 0);
		chk("field on", rd, 32'h88);
		acc(1, ADDR_IRQ, 32'h3);
		acc(1, ADDR_OPCTL, 32'h80);
		rf_lvl <= 8'hC0;
		cmd(CMD_FO_RESP);
		wait_irq(1);
		chk("collision irq", {30'h0, irq}, 32'h2);
		acc(0, ADDR_OPCTL, 0);
		chk("no field", rd, 32'h80);
		rf_lvl <= 8'h00;
		acc(1, ADDR_IRQ, 32'h3);
		cmd(CMD_FO_RESP_N0);
		wait_irq(0);
		chk("response time", n >= 19 && n <= 24, 1);
		// Auto response avoidance set: clear lands inside the delay
		acc(1, ADDR_OPCTL, 32'h80);
		acc(1, ADDR_MODEDEF, 32'h01);
		cmd(CMD_FO_RESP_N0);
		cmd(CMD_CLEAR);
		wait_irq(0);
		chk("kept avoidance", {30'h0, irq}, 32'h1);
		// host drops the auto bit before clear to cancel avoidance
		acc(1, ADDR_OPCTL, 32'h80);
		acc(1, ADDR_MODEDEF, 32'h00);
		cmd(CMD_FO_RESP_N0);
		cmd(CMD_CLEAR);
		repeat (40) @(posedge clk);
		chk("cancelled avoidance", {30'h0, irq}, 0);
		acc(0, ADDR_OPCTL, 0);
		chk("field stays off", rd, 32'h80);
		acc(1, ADDR_MODEDEF, 32'h08);
		rate <= 8'(rnd());
		cmd(CMD_GO_NORMAL);
		@(posedge clk);
		chk("rate copy", {24'h0, cfg.bitrate}, {24'h0, rate});
		chk("tx am", {31'h0, cfg.tx_am_select}, {31'h0, |rate[3:0]});
		// preset from a plain mode; all-zero settings preset to zero
		acc(1, ADDR_MODEDEF, 32'h00);
		acc(1, ADDR_BITRATE, 32'h00);
		acc(1, ADDR_RXCFG, 32'hFF);
		acc(1, ADDR_TXCFG, 32'hFF);
		cmd(CMD_ANALOG_PRE);
		@(posedge clk);
		chk("rx preset", {24'h0, cfg.rx_cfg}, 0);
		chk("tx preset", {24'h0, cfg.tx_cfg}, 0);
		cmd(CMD_SET_DEFAULT);
		@(posedge clk);
		chk("no set-default irq", {30'h0, irq}, 0);
		report_and_stop();
	end

	initial begin
		repeat (100000) @(posedge clk);
		fails++;
		report_and_stop();
	end
endmodule
